// file: common/socket_pkg.sv
// Package for the socket packet controller: header layout, codes,
// own register map, state record and timing constants.
// Assumes one 100 MHz clock shared by all users of the package.
package socket_pkg;

    // Operation codes
    localparam logic [15:0] op_invalid = 16'h0000;
    localparam logic [15:0] op_connect_request = 16'h0001;
    localparam logic [15:0] op_connect_response = 16'h0002;
    localparam logic [15:0] op_reset = 16'h0003;
    localparam logic [15:0] op_shutdown = 16'h0004;
    localparam logic [15:0] op_data_transfer = 16'h0005;
    localparam logic [15:0] op_credit_update = 16'h0006;
    localparam logic [15:0] op_credit_query = 16'h0007;

    // Socket types
    localparam logic [15:0] type_stream = 16'h0001;
    localparam logic [15:0] type_seqpacket = 16'h0002;

    // Flag bit positions
    localparam int no_more_receive_flag = 0;
    localparam int no_more_send_flag = 1;
    localparam int end_of_message_flag = 0;
    localparam int end_of_record_flag = 1;
    localparam logic [31:0] shutdown_both = 32'h0000_0003;

    // Reserved context IDs
    localparam logic [63:0] cid_reserved_0 = 64'h0;
    localparam logic [63:0] cid_reserved_1 = 64'h1;
    localparam logic [63:0] cid_host = 64'h2;
    localparam logic [63:0] cid_reserved_28 = 64'h0000_0000_0FFF_FFFF;
    localparam logic [63:0] cid_reserved_ones = 64'hFFFF_FFFF_FFFF_FFFF;
    localparam logic [63:0] cid_reserved_32 = 64'h0000_0000_FFFF_FFFF;

    // Register offsets
    localparam logic [7:0] reg_ctrl = 8'h00;
    localparam logic [7:0] reg_mode = 8'h04;
    localparam logic [7:0] reg_local_port = 8'h08;
    localparam logic [7:0] reg_peer_port = 8'h0C;
    localparam logic [7:0] reg_peer_cid = 8'h10;
    localparam logic [7:0] reg_buf_alloc = 8'h14;
    localparam logic [7:0] reg_data_len = 8'h18;
    localparam logic [7:0] reg_seq_flags = 8'h1C;
    localparam logic [7:0] reg_status = 8'h20;
    localparam logic [7:0] reg_peer_free = 8'h24;
    localparam logic [7:0] reg_tx_cnt = 8'h28;
    localparam logic [7:0] reg_fwd_cnt = 8'h2C;

    // Command bits of the control register, listen bit of the mode register
    localparam int ctrl_connect = 0;
    localparam int ctrl_shutdown = 1;
    localparam int ctrl_abort = 2;
    localparam int ctrl_send = 3;
    localparam int ctrl_query = 4;
    localparam int ctrl_update = 5;
    localparam int mode_listen = 16;

    // Clean-disconnect wait
    localparam int clock_mhz = 100;
    localparam int shutdown_timeout_us = 1000;
    localparam int shutdown_timeout_cycles = shutdown_timeout_us * clock_mhz;

    typedef struct packed {
        logic [63:0] src_cid;
        logic [63:0] dst_cid;
        logic [31:0] src_port;
        logic [31:0] dst_port;
        logic [31:0] len;
        logic [15:0] sock_type;
        logic [15:0] op;
        logic [31:0] flags;
        logic [31:0] buf_alloc;
        logic [31:0] fwd_cnt;
    } socket_hdr_t;

    typedef enum logic [1:0] {conn_closed, conn_connecting, conn_established, conn_closing}
        conn_state_t;

    typedef struct packed {
        conn_state_t conn;
        logic tx_busy;
        socket_hdr_t tx_hdr;
        logic reply_pend;
        logic [15:0] reply_op;
        logic [31:0] reply_cid;
        logic [31:0] reply_port;
        logic [31:0] reply_lport;
        logic cmd_pend;
        logic [15:0] cmd_op;
        logic [31:0] cmd_flags;
        logic force_rst;
        logic timer_run;
        logic [31:0] timer;
        logic [31:0] tx_cnt;
        logic [31:0] fwd_cnt;
        logic [31:0] peer_alloc;
        logic [31:0] peer_fwd;
        logic [1:0] peer_shut;
        logic [31:0] local_port;
        logic [31:0] peer_port;
        logic [31:0] peer_cid;
        logic [31:0] buf_alloc;
        logic [31:0] data_len;
        logic [1:0] seq_flags;
        logic [15:0] sock_type;
        logic listen_en;
        logic [31:0] rdata;
    } socket_state_t;

    localparam socket_state_t state_reset =
        '{conn: conn_closed, sock_type: type_stream, default: '0};

endpackage

// file: src/socket_driver_engine.sv
// Driver-side protocol engine for one socket flow: builds transmit
// headers, parses received headers, keeps credit and connection state.
// Assumes all inputs synchronous to clock; header fields are presented
// as decoded values, byte order handled by the queue transport.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Ten-field header, context ID upper half zero
// - Operation codes zero through seven
// - Only length bytes of payload count
// - Driver keeps draining rx while spare
// - Spare storage exhausted stalls incoming packets
// - Flow is both context IDs and ports
// - Socket type one stream, two seqpacket
// - Credit counts payload bytes, never headers
// - Advertise buffer size and received count
// - Peer free space by wrapping subtraction
// - Send data only when credit covers it
// - Credit query answered with credit update
// - Every packet carries current credit fields
// - Source context ID is guest ID
// - Unknown socket type answered with reset
// - Connect answered by response or reset
// - Shutdown hints sticky once seen
// - Reset aborts or tears down connection
// - Clean close: shutdown, await reset, timeout
// - Seqpacket end-of-message and end-of-record flags
module socket_driver_engine
    import socket_pkg::*;
#(
    parameter int timeout_cycles = shutdown_timeout_cycles
)
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    input wire logic [63:0] guest_cid,
    output logic tx_valid,
    input wire logic tx_ready,
    output socket_hdr_t tx_hdr,
    input wire logic rx_valid,
    output logic rx_ready,
    input wire socket_hdr_t rx_hdr
);

    socket_state_t q;
    socket_state_t d;
    logic [31:0] peer_free;
    logic credit_ok;
    logic cid_ok;
    logic rx_take;
    logic flow_match;
    logic type_known;
    logic load_cmd;

    function automatic logic cid_reserved(input logic [63:0] cid);
        cid_reserved = (cid == cid_reserved_0) || (cid == cid_reserved_1) ||
            (cid == cid_host) || (cid == cid_reserved_28) ||
            (cid == cid_reserved_32) || (cid == cid_reserved_ones) ||
            (cid[63:32] != 32'h0);
    endfunction

    function automatic socket_hdr_t make_hdr(input logic [63:0] gcid,
        input logic [31:0] dcid, input logic [31:0] sport, input logic [31:0] dport,
        input logic [31:0] len, input logic [15:0] typ, input logic [15:0] op,
        input logic [31:0] flags, input logic [31:0] alloc, input logic [31:0] fwd);
        socket_hdr_t h;
        h.src_cid = {32'h0, gcid[31:0]};
        h.dst_cid = {32'h0, dcid};
        h.src_port = sport;
        h.dst_port = dport;
        h.len = len;
        h.sock_type = typ;
        h.op = op;
        h.flags = flags;
        h.buf_alloc = alloc;
        h.fwd_cnt = fwd;
        make_hdr = h;
    endfunction

    function automatic logic [31:0] read_value(input logic [7:0] addr,
        input socket_state_t s, input logic [31:0] pfree, input logic cok,
        input logic gok);
        case (addr)
            reg_mode: read_value = {15'h0, s.listen_en, s.sock_type};
            reg_local_port: read_value = s.local_port;
            reg_peer_port: read_value = s.peer_port;
            reg_peer_cid: read_value = s.peer_cid;
            reg_buf_alloc: read_value = s.buf_alloc;
            reg_data_len: read_value = s.data_len;
            reg_seq_flags: read_value = {30'h0, s.seq_flags};
            reg_status: read_value = {22'h0, s.timer_run, gok, cok, s.peer_shut,
                s.tx_busy, s.reply_pend, s.cmd_pend, s.conn};
            reg_peer_free: read_value = pfree;
            reg_tx_cnt: read_value = s.tx_cnt;
            reg_fwd_cnt: read_value = s.fwd_cnt;
            default: read_value = 32'h0;
        endcase
    endfunction

    assign peer_free = q.peer_alloc - (q.tx_cnt - q.peer_fwd);
    assign credit_ok = peer_free >= q.data_len;
    assign cid_ok = !cid_reserved(guest_cid);
    assign rx_ready = !q.reply_pend;
    assign rx_take = rx_valid && rx_ready;
    assign flow_match = (rx_hdr.src_cid[31:0] == q.peer_cid) &&
        (rx_hdr.src_port == q.peer_port) && (rx_hdr.dst_port == q.local_port) &&
        (rx_hdr.dst_cid[31:0] == guest_cid[31:0]);
    assign type_known = (rx_hdr.sock_type == type_stream) ||
        (rx_hdr.sock_type == type_seqpacket);
    assign load_cmd = !q.tx_busy && !q.reply_pend && !q.force_rst && q.cmd_pend &&
        ((q.cmd_op != op_data_transfer) || credit_ok);
    assign tx_valid = q.tx_busy;
    assign tx_hdr = q.tx_hdr;
    assign reg_rdata = q.rdata;

    always_comb
    begin
        d = q;
        d.rdata = reg_read ? read_value(reg_addr, q, peer_free, credit_ok, cid_ok) : 32'h0;
        if (reg_write)
        begin
            case (reg_addr)
                reg_mode:
                begin
                    d.sock_type = reg_wdata[15:0];
                    d.listen_en = reg_wdata[mode_listen];
                end
                reg_local_port: d.local_port = reg_wdata;
                reg_peer_port: d.peer_port = reg_wdata;
                reg_peer_cid: d.peer_cid = reg_wdata;
                reg_buf_alloc: d.buf_alloc = reg_wdata;
                reg_data_len: d.data_len = reg_wdata;
                reg_seq_flags: d.seq_flags = reg_wdata[1:0];
                reg_ctrl:
                begin
                    if (!q.cmd_pend)
                    begin
                        d.cmd_flags = 32'h0;
                        if (reg_wdata[ctrl_connect] && q.conn == conn_closed && cid_ok)
                        begin
                            d.cmd_pend = 1'b1;
                            d.cmd_op = op_connect_request;
                            d.conn = conn_connecting;
                            d.peer_shut = 2'b00;
                            d.tx_cnt = 32'h0;
                            d.fwd_cnt = 32'h0;
                            d.peer_alloc = 32'h0;
                            d.peer_fwd = 32'h0;
                        end
                        else if (reg_wdata[ctrl_shutdown] && q.conn == conn_established)
                        begin
                            d.cmd_pend = 1'b1;
                            d.cmd_op = op_shutdown;
                            d.cmd_flags = shutdown_both;
                            d.conn = conn_closing;
                        end
                        else if (reg_wdata[ctrl_abort] && q.conn != conn_closed)
                        begin
                            d.cmd_pend = 1'b1;
                            d.cmd_op = op_reset;
                            d.conn = conn_closed;
                            d.timer_run = 1'b0;
                        end
                        else if (q.conn == conn_established)
                        begin
                            if (reg_wdata[ctrl_send])
                            begin
                                d.cmd_pend = 1'b1;
                                d.cmd_op = op_data_transfer;
                                if (q.sock_type == type_seqpacket)
                                    d.cmd_flags = {30'h0, q.seq_flags};
                            end
                            else if (reg_wdata[ctrl_query])
                            begin
                                d.cmd_pend = 1'b1;
                                d.cmd_op = op_credit_query;
                            end
                            else if (reg_wdata[ctrl_update])
                            begin
                                d.cmd_pend = 1'b1;
                                d.cmd_op = op_credit_update;
                            end
                        end
                    end
                end
                default:
                begin
                end
            endcase
        end
        // Transmit hand-off and accounting
        if (q.tx_busy && tx_ready)
        begin
            d.tx_busy = 1'b0;
            if (q.tx_hdr.op == op_data_transfer)
                d.tx_cnt = q.tx_cnt + q.tx_hdr.len;
            if (q.tx_hdr.op == op_shutdown && q.tx_hdr.flags == shutdown_both)
            begin
                d.timer_run = 1'b1;
                d.timer = 32'(timeout_cycles);
            end
        end
        // Transmit load: replies first, then forced reset, then commands
        if (!q.tx_busy && q.reply_pend)
        begin
            d.tx_busy = 1'b1;
            d.reply_pend = 1'b0;
            d.tx_hdr = make_hdr(guest_cid, q.reply_cid, q.reply_lport, q.reply_port, 32'h0,
                q.sock_type, q.reply_op, 32'h0, q.buf_alloc, q.fwd_cnt);
        end
        else if (!q.tx_busy && q.force_rst)
        begin
            d.tx_busy = 1'b1;
            d.force_rst = 1'b0;
            d.tx_hdr = make_hdr(guest_cid, q.peer_cid, q.local_port, q.peer_port, 32'h0,
                q.sock_type, op_reset, 32'h0, q.buf_alloc, q.fwd_cnt);
        end
        else if (load_cmd)
        begin
            d.tx_busy = 1'b1;
            d.cmd_pend = 1'b0;
            d.tx_hdr = make_hdr(guest_cid, q.peer_cid, q.local_port, q.peer_port,
                (q.cmd_op == op_data_transfer) ? q.data_len : 32'h0,
                q.sock_type, q.cmd_op, q.cmd_flags, q.buf_alloc, q.fwd_cnt);
        end
        // Clean-disconnect timeout
        if (q.timer_run)
        begin
            if (q.timer <= 32'h1)
            begin
                d.timer_run = 1'b0;
                d.force_rst = 1'b1;
                d.conn = conn_closed;
            end
            else
                d.timer = q.timer - 32'h1;
        end
        // Receive parsing; a taken packet may queue one reply
        if (rx_take)
        begin
            d.reply_cid = rx_hdr.src_cid[31:0];
            d.reply_port = rx_hdr.src_port;
            d.reply_lport = rx_hdr.dst_port;
            if (!type_known)
            begin
                d.reply_pend = 1'b1;
                d.reply_op = op_reset;
            end
            else if (rx_hdr.op == op_connect_request)
            begin
                d.reply_pend = 1'b1;
                if (q.listen_en && q.conn == conn_closed && !q.cmd_pend &&
                    rx_hdr.dst_port == q.local_port)
                begin
                    d.reply_op = op_connect_response;
                    d.conn = conn_established;
                    d.peer_cid = rx_hdr.src_cid[31:0];
                    d.peer_port = rx_hdr.src_port;
                    d.peer_alloc = rx_hdr.buf_alloc;
                    d.peer_fwd = rx_hdr.fwd_cnt;
                    d.peer_shut = 2'b00;
                    d.tx_cnt = 32'h0;
                    d.fwd_cnt = 32'h0;
                end
                else
                    d.reply_op = op_reset;
            end
            else if (flow_match && q.conn != conn_closed)
            begin
                d.peer_alloc = rx_hdr.buf_alloc;
                d.peer_fwd = rx_hdr.fwd_cnt;
                case (rx_hdr.op)
                    op_connect_response:
                        if (q.conn == conn_connecting)
                            d.conn = conn_established;
                    op_reset:
                    begin
                        d.conn = conn_closed;
                        d.timer_run = 1'b0;
                        d.force_rst = 1'b0;
                    end
                    op_shutdown:
                        d.peer_shut = q.peer_shut | rx_hdr.flags[1:0];
                    op_data_transfer:
                        d.fwd_cnt = q.fwd_cnt + rx_hdr.len;
                    op_credit_query:
                    begin
                        d.reply_pend = 1'b1;
                        d.reply_op = op_credit_update;
                    end
                    default:
                    begin
                    end
                endcase
            end
            else if (rx_hdr.op != op_reset)
            begin
                d.reply_pend = 1'b1;
                d.reply_op = op_reset;
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            q <= state_reset;
        else
            q <= d;
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    a_cid_upper_zero: assert property (tx_valid |-> tx_hdr.src_cid[63:32] == 32'h0 &&
        tx_hdr.dst_cid[63:32] == 32'h0)
        else $error("context ID upper half not zero");
    a_source_guest_cid: assert property (tx_valid |->
        tx_hdr.src_cid[31:0] == guest_cid[31:0])
        else $error("source context ID differs from guest ID");
    a_data_has_credit: assert property (load_cmd && q.cmd_op == op_data_transfer |->
        q.peer_alloc - (q.tx_cnt - q.peer_fwd) >= q.data_len ##1 tx_valid && tx_hdr.len ==
        $past(q.data_len))
        else $error("data sent without peer credit");
    a_tx_count_payload: assert property (tx_valid && tx_ready &&
        tx_hdr.op == op_data_transfer |=> q.tx_cnt == $past(q.tx_cnt) + $past(tx_hdr.len))
        else $error("transmit count not advanced by payload");
    a_query_gets_update: assert property (rx_take && flow_match && type_known &&
        q.conn != conn_closed && rx_hdr.op == op_credit_query && !tx_valid && !load_cmd &&
        !q.force_rst |=> !rx_ready ##1 tx_valid && tx_hdr.op == op_credit_update)
        else $error("credit query not answered");
    a_unknown_type_reset: assert property (rx_take && !type_known && !tx_valid &&
        !load_cmd |=> q.reply_pend && q.reply_op == op_reset ##1 tx_valid &&
        tx_hdr.op == op_reset)
        else $error("unknown type not answered with reset");
    a_rx_stall_full: assert property (q.reply_pend && q.tx_busy |=> q.reply_pend &&
        $stable(q.reply_cid) && $stable(q.reply_op) && $stable(q.reply_port))
        else $error("receive taken with reply storage full");
    a_shut_sticky: assert property (q.peer_shut[0] && !(reg_write && reg_addr == reg_ctrl) &&
        !(rx_take && rx_hdr.op == op_connect_request) |=> q.peer_shut[0])
        else $error("shutdown hint lost");
    a_peer_reset_close: assert property (rx_take && flow_match && type_known &&
        q.conn != conn_closed && rx_hdr.op == op_reset |=> q.conn == conn_closed &&
        !q.timer_run)
        else $error("peer reset did not close");
    a_connect_answer: assert property (rx_take && type_known &&
        rx_hdr.op == op_connect_request |=> q.reply_pend && (q.reply_op ==
        op_connect_response || q.reply_op == op_reset))
        else $error("connect request not answered");
    a_timeout_reset: assert property (q.timer_run && q.timer == 32'h1 &&
        !(rx_take && rx_hdr.op == op_reset) |=> q.force_rst && q.conn == conn_closed)
        else $error("timeout did not force reset");

    c_connect_done: cover property (q.conn == conn_connecting ##[1:50] q.conn == conn_established);
    c_data_sent: cover property (tx_valid && tx_ready && tx_hdr.op == op_data_transfer);
    c_clean_close: cover property (q.timer_run ##[1:50] rx_take && rx_hdr.op == op_reset);
    c_rx_stalled: cover property (rx_valid && !rx_ready);

endmodule

`default_nettype wire

// file: tb/socket_peer_model.sv
// Far side of the socket engine: takes transmit headers, offers receive
// headers. Assumes tb drives slow; one clock shared with the engine.
`timescale 1ns/1ps
`default_nettype none
module socket_peer_model
    import socket_pkg::*;
(
    input wire logic clock,
    input wire logic slow,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire socket_hdr_t tx_hdr,
    output logic rx_valid,
    input wire logic rx_ready,
    output socket_hdr_t rx_hdr,
    output socket_hdr_t last,
    output int taken
);
    int w;
    initial
    begin
        tx_ready = 0;
        rx_valid = 0;
        rx_hdr = '0;
        taken = 0;
        w = 0;
    end
    // Drains tx, promptly or after a stall
    always @(posedge clock)
    begin
        tx_ready <= tx_valid && !tx_ready && (!slow || w >= 3);
        w <= tx_valid ? w + 1 : 0;
        if (tx_valid && tx_ready)
        begin
            last <= tx_hdr;
            taken <= taken + 1;
        end
    end
    // Header carries credit fields given by caller
    task send(input socket_hdr_t h);
        logic r;
        @(posedge clock);
        rx_valid <= 1;
        rx_hdr <= h;
        forever
        begin
            #1 r = rx_ready;
            @(posedge clock);
            if (r)
                break;
        end
        rx_valid <= 0;
        rx_hdr <= ~h;
    endtask
endmodule
`default_nettype wire

// file: tb/socket_packet_protocol_engine_test.sv
// Bench for the socket engine: register tasks, peer model, sequences.
// Assumes the engine with a short disconnect timeout.
`timescale 1ns/1ps
`default_nettype none
module socket_packet_protocol_engine_test;
    import socket_pkg::*;
    logic clock = 0;
    logic reset_n = 0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_write = 0;
    logic reg_read = 0;
    logic [31:0] reg_rdata;
    logic [63:0] guest_cid = 64'h2;
    logic slow = 0;
    logic tx_valid, tx_ready, rx_valid, rx_ready;
    socket_hdr_t tx_hdr, rx_hdr, last;
    int taken, num_errors = 0, checks_done = 0, cycles = 0;
    always #5 clock = ~clock;
    socket_driver_engine #(.timeout_cycles(20)) socket_driver_engine_i (.clock(clock),
        .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .guest_cid(guest_cid), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_hdr(tx_hdr), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_hdr(rx_hdr));
    socket_peer_model socket_peer_model_i (.clock(clock), .slow(slow),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_hdr(tx_hdr), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_hdr(rx_hdr), .last(last), .taken(taken));
    task end_of_test;
        if (num_errors == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            num_errors++;
            end_of_test;
        end
    end
    task chk(input logic [63:0] s, input logic [63:0] e);
        checks_done++;
        if (s !== e)
        begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, s, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1;
        @(posedge clock);
        reg_write <= 0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1;
        @(posedge clock);
        reg_read <= 0;
        #1 chk(reg_rdata & m, e);
    endtask
    // Waits for the peer to take headers, then checks how many came
    task wtx(input int lim, input int exp);
        int t0;
        int i;
        t0 = taken;
        i = 0;
        while ((taken == t0 || exp == 0) && i < lim)
        begin
            @(posedge clock);
            #1 i++;
        end
        chk(64'(taken - t0), 64'(exp));
    endtask
    function automatic socket_hdr_t mk(logic [15:0] op, logic [15:0] ty, logic [31:0] fl,
        logic [31:0] ln, logic [31:0] fw);
        mk = '{64'h3, 64'h5, 32'h20, 32'h10, ln, ty, op, fl, 32'h40, fw};
    endfunction
    initial
    begin
        repeat (8) @(posedge clock);
        reset_n <= 1;
        rd(reg_status, 32'hFFFFFFFF, 32'h80);
        rd(8'hFC, 32'hFFFFFFFF, 32'h0);
        wr(reg_ctrl, 32'h1);
        wtx(8, 0);
        rd(reg_status, 32'h3, 32'h0);
        guest_cid <= 64'h5;
        wr(reg_mode, 32'h1);
        wr(reg_local_port, 32'h10);
        wr(reg_peer_port, 32'h20);
        wr(reg_peer_cid, 32'h3);
        wr(reg_buf_alloc, 32'h100);
        wr(reg_ctrl, 32'h1);
        wtx(20, 1);
        chk({last.op, last.sock_type}, {op_connect_request, type_stream});
        chk(last.src_cid, 64'h5);
        chk(last.dst_cid, 64'h3);
        chk({last.src_port, last.dst_port}, {32'h10, 32'h20});
        chk({last.buf_alloc, last.fwd_cnt}, {32'h100, 32'h0});
        socket_peer_model_i.send(mk(op_connect_response, type_stream, 0, 0, 0));
        rd(reg_status, 32'h3, 32'h2);
        wr(reg_data_len, 32'h30);
        wr(reg_ctrl, 32'h8);
        wtx(20, 1);
        chk({last.op, last.len}, {op_data_transfer, 32'h30});
        rd(reg_peer_free, 32'hFFFFFFFF, 32'h10);
        rd(reg_tx_cnt, 32'hFFFFFFFF, 32'h30);
        wr(reg_data_len, 32'h20);
        wr(reg_ctrl, 32'h8);
        wtx(10, 0);
        socket_peer_model_i.send(mk(op_credit_update, type_stream, 0, 0, 32'h30));
        wtx(20, 1);
        chk(last.len, 32'h20);
        rd(reg_peer_free, 32'hFFFFFFFF, 32'h20);
        socket_peer_model_i.send(mk(op_data_transfer, type_stream, 0, 8, 32'h30));
        rd(reg_fwd_cnt, 32'hFFFFFFFF, 32'h8);
        socket_peer_model_i.send(mk(op_credit_query, type_stream, 0, 0, 32'h30));
        wtx(20, 1);
        chk({last.op, last.fwd_cnt}, {op_credit_update, 32'h8});
        socket_peer_model_i.send(mk(op_credit_update, 16'h9, 0, 0, 32'h30));
        wtx(20, 1);
        chk(last.op, op_reset);
        socket_peer_model_i.send(mk(op_shutdown, type_stream, 1, 0, 32'h30));
        socket_peer_model_i.send(mk(op_shutdown, type_stream, 0, 0, 32'h30));
        rd(reg_status, 32'h60, 32'h20);
        slow <= 1;
        wr(reg_ctrl, 32'h2);
        wtx(20, 1);
        chk({last.op, last.flags}, {op_shutdown, shutdown_both});
        rd(reg_status, 32'h3, 32'h3);
        wtx(12, 0);
        wtx(40, 1);
        chk(last.op, op_reset);
        rd(reg_status, 32'h3, 32'h0);
        socket_peer_model_i.send(mk(op_connect_request, type_stream, 0, 0, 0));
        wtx(20, 1);
        chk(last.op, op_reset);
        wr(reg_mode, 32'h0001_0002);
        socket_peer_model_i.send(mk(op_connect_request, type_seqpacket, 0, 0, 0));
        wtx(20, 1);
        chk({last.op, last.sock_type}, {op_connect_response, type_seqpacket});
        rd(reg_status, 32'h3, 32'h2);
        wr(reg_seq_flags, 32'h3);
        wr(reg_data_len, 32'h8);
        wr(reg_ctrl, 32'h8);
        wtx(20, 1);
        chk({last.op, last.flags}, {op_data_transfer, 32'h3});
        wr(reg_ctrl, 32'h10);
        socket_peer_model_i.send(mk(op_credit_query, type_seqpacket, 0, 0, 0));
        wtx(20, 1);
        chk(last.op, op_credit_query);
        wtx(20, 1);
        chk({last.op, last.fwd_cnt}, {op_credit_update, 32'h0});
        wr(reg_ctrl, 32'h20);
        wtx(20, 1);
        chk({last.op, last.buf_alloc}, {op_credit_update, 32'h100});
        wr(reg_ctrl, 32'h2);
        wtx(20, 1);
        socket_peer_model_i.send(mk(op_reset, type_seqpacket, 0, 0, 0));
        rd(reg_status, 32'h203, 32'h0);
        wtx(30, 0);
        wr(reg_ctrl, 32'h1);
        wtx(20, 1);
        wr(reg_ctrl, 32'h4);
        wtx(20, 1);
        chk(last.op, op_reset);
        rd(reg_status, 32'h3, 32'h0);
        end_of_test;
    end
endmodule
`default_nettype wire
